// ==== blrg_pkg.sv ====
// Purpose: Constants and types shared by the board LED and rear GPIO register block.
// Assumes: Avalon-MM byte-wide registers, one aligned 32-bit word per register.
// Notes:   Printed offsets are not multiples of four, so byte address is four times the index.
package blrg_pkg;
    localparam int unsigned      ADDR_W           = 12;
    localparam logic [11:0]      IDX_LED_SETUP    = 12'h290;
    localparam logic [11:0]      IDX_LED_CMD      = 12'h291;
    localparam logic [11:0]      IDX_REAR_OUT     = 12'h292;
    localparam logic [11:0]      IDX_REAR_IN      = 12'h293;
    localparam logic [11:0]      IDX_POST_CODE    = 12'h294;
    localparam logic [3:0]       SETUP_POST       = 4'h0;
    localparam logic [3:0]       SETUP_GP         = 4'h1;
    localparam logic [3:0]       SETUP_RESET      = 4'h0;
    localparam logic [7:0]       LED_CMD_RESET    = 8'h00;
    localparam logic [2:0]       REAR_OUT_RESET   = 3'h0;
    localparam logic [4:0]       REAR_IN_RESET    = 5'h1F;
    localparam int unsigned      CMD_HI           = 7;
    localparam int unsigned      CMD_LO           = 4;
    localparam int unsigned      COL_HI           = 3;
    localparam int unsigned      COL_LO           = 0;
    localparam logic [1:0]       CMD_GET          = 2'h0;
    localparam logic [1:0]       CMD_SET          = 2'h2;
    localparam logic [1:0]       COL_OFF          = 2'h0;
    localparam int unsigned      NUM_LEDS         = 4;
    localparam int unsigned      NUM_OUT          = 3;
    localparam int unsigned      NUM_IN           = 5;
endpackage : blrg_pkg

// ==== blrg_sync_if.sv ====
// Purpose: Carries raw rear input levels into the synchroniser and the settled levels back.
// Assumes: Single clock domain on the settled side.
// Notes:   The settled word is only valid two edges after a pin change.
`timescale 1ns/1ns
interface blrg_sync_if;
    logic [4:0] raw_level;
    logic [4:0] settled_level;
    modport owner (output raw_level, input settled_level);
    modport sync  (input raw_level, output settled_level);
endinterface : blrg_sync_if

// ==== blrg_sync.sv ====
// Purpose: Two-stage synchroniser for the rear input pins.
// Assumes: Pins are pulled up, so reset loads ones.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
module blrg_sync
(
    input  wire logic clk,
    input  wire logic rstn,
    blrg_sync_if.sync port_io
);
    typedef struct packed
    {
        logic [4:0] meta;
        logic [4:0] stable;
    } blrg_sync_state_t;

    blrg_sync_state_t state;
    blrg_sync_state_t next_state;

    always_comb
    begin
        next_state.meta   = port_io.raw_level;
        next_state.stable = state.meta;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= {blrg_pkg::REAR_IN_RESET, blrg_pkg::REAR_IN_RESET};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign port_io.settled_level = state.stable;
endmodule : blrg_sync

// ==== blrg_regs.sv ====
// Purpose: Front LED command/colour logic and rear GPIO registers behind Avalon-MM.
// Assumes: Single 100 MHz clock, asynchronous active-low reset.
// Notes:   Reads answer one cycle after the request; writes complete in the request cycle.
// Summary of operation
// - LED command register at index 0x291 switches each of four LEDs.
// - LED register writes only drive LEDs while setup selects general-purpose mode.
// - Setup value 0001 selects general-purpose mode; other nonzero values reserved.
// - Setup value 0000 selects POST mode; green LEDs show the low four POST code bits, red stays off.
// - Output register at index 0x292 drives three rear output pins.
// - Output bit 0 drives low, 1 drives high; all zero after reset.
// - Read-only input register at index 0x293 shows five rear input pins.
// - Input bit reads 0 for a low pin and 1 for a high pin.
// - Pulled-up inputs read as ones when unconnected.
// - Rear GPIO works only when the rear module enables GPIO.
`timescale 1ns/1ns
module blrg_regs
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    input  wire logic [7:0]  post_code_in,
    input  wire logic        post_code_valid,
    input  wire logic        rear_gpio_enable,
    input  wire logic [4:0]  rear_input_bit,
    output logic [2:0]       rear_output_bit,
    output logic [3:0]       led_green,
    output logic [3:0]       led_red
);
    typedef struct packed
    {
        logic [3:0]  led_setup_field;
        logic [7:0]  led_command_colour;
        logic [7:0]  led_colour_store;
        logic [7:0]  post_code;
        logic [2:0]  rear_output_pins;
        logic        gpio_en_meta;
        logic        gpio_en;
        logic        rd_pending;
        logic [31:0] rdata;
        logic [1:0]  resp;
        logic [2:0]  out_pins;
        logic [3:0]  green;
        logic [3:0]  red;
    } blrg_state_t;

    blrg_state_t state;
    blrg_state_t next_state;
    blrg_sync_if sync_bus ();

    assign sync_bus.raw_level = rear_input_bit;

    blrg_sync u_sync
    (
        .clk     (clk),
        .rstn    (rstn),
        .port_io (sync_bus.sync)
    );

    // Word index from the byte address; index sits above the two lane bits.
    function automatic logic [11:0] blrg_index(input logic [11:0] byte_addr);
        blrg_index = {2'h0, byte_addr[11:2]};
    endfunction : blrg_index

    function automatic logic blrg_mapped(input logic [11:0] idx);
        blrg_mapped = (idx >= blrg_pkg::IDX_LED_SETUP) && (idx <= blrg_pkg::IDX_POST_CODE);
    endfunction : blrg_mapped

    logic [11:0] idx;
    logic [3:0]  cmd;
    logic [3:0]  col;
    logic        wr_low;

    always_comb
    begin
        next_state = state;
        idx        = blrg_index(avs_address);
        wr_low     = avs_write && avs_byteenable[0];
        cmd        = avs_writedata[blrg_pkg::CMD_HI:blrg_pkg::CMD_LO];
        col        = avs_writedata[blrg_pkg::COL_HI:blrg_pkg::COL_LO];
        next_state.gpio_en_meta = rear_gpio_enable;
        next_state.gpio_en      = state.gpio_en_meta;
        if (post_code_valid)
        begin
            next_state.post_code = post_code_in;
        end
        next_state.rd_pending = avs_read && !state.rd_pending;
        if (wr_low)
        begin
            if (idx == blrg_pkg::IDX_LED_SETUP)
            begin
                next_state.led_setup_field = avs_writedata[3:0];
            end
            else if (idx == blrg_pkg::IDX_LED_CMD)
            begin
                // Command is stored so a get returns the selected colour on read.
                next_state.led_command_colour = avs_writedata[7:0];
                if (cmd[3:2] == blrg_pkg::CMD_SET && state.led_setup_field == blrg_pkg::SETUP_GP)
                begin
                    next_state.led_colour_store[cmd[1:0]*2 +: 2] = col[1:0];
                end
            end
            else if (idx == blrg_pkg::IDX_REAR_OUT && state.gpio_en)
            begin
                next_state.rear_output_pins = avs_writedata[2:0];
            end
        end
        if (avs_read && !state.rd_pending)
        begin
            next_state.rdata = 32'h0000_0000;
            next_state.resp  = blrg_mapped(idx) ? 2'h0 : 2'h2;
            if (idx == blrg_pkg::IDX_LED_SETUP)
            begin
                next_state.rdata[3:0] = state.led_setup_field;
            end
            else if (idx == blrg_pkg::IDX_LED_CMD)
            begin
                next_state.rdata[7:4] = state.led_command_colour[7:4];
                if (state.led_command_colour[7:6] == blrg_pkg::CMD_GET)
                begin
                    next_state.rdata[1:0] =
                        state.led_colour_store[state.led_command_colour[5:4]*2 +: 2];
                end
                else
                begin
                    next_state.rdata[3:0] = state.led_command_colour[3:0];
                end
            end
            else if (idx == blrg_pkg::IDX_REAR_OUT)
            begin
                next_state.rdata[2:0] = state.rear_output_pins;
            end
            else if (idx == blrg_pkg::IDX_REAR_IN)
            begin
                // Disabled rear GPIO shows the pulled-up idle pattern.
                next_state.rdata[4:0] = state.gpio_en ? sync_bus.settled_level
                                                      : blrg_pkg::REAR_IN_RESET;
            end
            else if (idx == blrg_pkg::IDX_POST_CODE)
            begin
                next_state.rdata[7:0] = state.post_code;
            end
        end
        // Outputs held low while the rear module has not enabled GPIO.
        next_state.out_pins = state.gpio_en ? state.rear_output_pins : blrg_pkg::REAR_OUT_RESET;
        for (int i = 0; i < 4; i++)
        begin
            if (state.led_setup_field == blrg_pkg::SETUP_GP)
            begin
                next_state.green[i] = state.led_colour_store[2*i];
                next_state.red[i]   = state.led_colour_store[2*i + 1];
            end
            else if (state.led_setup_field == blrg_pkg::SETUP_POST)
            begin
                next_state.green[i] = state.post_code[i];
                next_state.red[i]   = 1'b0;
            end
            else
            begin
                next_state.green[i] = 1'b0;
                next_state.red[i]   = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Waitrequest drops in the second cycle of a read so data stand at that edge.
    always_comb
    begin
        avs_waitrequest = avs_read && !state.rd_pending;
    end

    assign avs_readdata    = state.rdata;
    assign avs_response    = state.resp;
    assign rear_output_bit = state.out_pins;
    assign led_green       = state.green;
    assign led_red         = state.red;
endmodule : blrg_regs

// ==== blrg_checker.sv ====
// Purpose: Port assertions for the LED and rear GPIO register block.
// Assumes: Rear enable and pins held steady for several cycles around checks.
// Notes:   Setup mode is shadowed from bus writes.
`timescale 1ns/1ns
module blrg_checker
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [11:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic        post_code_valid,
    input wire logic        rear_gpio_enable,
    input wire logic [4:0]  rear_input_bit,
    input wire logic [2:0]  rear_output_bit,
    input wire logic [3:0]  led_green,
    input wire logic [3:0]  led_red
);
    logic gp;
    wire  wr0 = avs_write && avs_byteenable[0];
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) gp <= 1'h0;
        else if (wr0 && avs_address == 12'hA40) gp <= avs_writedata[3:0] == 4'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence en_on; rear_gpio_enable[*4]; endsequence
    sequence en_off; !rear_gpio_enable[*4]; endsequence
    sequence rd_ack(a); avs_read && !avs_waitrequest && avs_address == a; endsequence
    wr_no_wait_a: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    gpo_write_a: assert property (en_on ##0 wr0 && avs_address == 12'hA48
        |-> ##2 rear_output_bit == $past(avs_writedata[2:0], 2)) else $error("output pins");
    gpo_off_a: assert property (en_off |-> rear_output_bit == 3'h0)
        else $error("outputs not forced low");
    gpi_read_a: assert property ((rear_gpio_enable && $stable(rear_input_bit))[*4]
        ##0 rd_ack(12'hA4C) |-> avs_readdata == {27'h0, rear_input_bit}) else $error("inputs");
    gpi_off_a: assert property (en_off ##0 rd_ack(12'hA4C) |-> avs_readdata == 32'h1F)
        else $error("disabled inputs");
    unmapped_a: assert property (rd_ack(12'hA60) |-> avs_response == 2'h2)
        else $error("unmapped response");
    led_set_a: assert property (
        gp && wr0 && avs_address == 12'hA44 && avs_writedata[7:6] == 2'h2
        |-> ##2 {led_red[$past(avs_writedata[5:4], 2)], led_green[$past(avs_writedata[5:4], 2)]}
        == $past(avs_writedata[1:0], 2)) else $error("led colour");
    post_hold_a: assert property ((!gp && !post_code_valid)[*4]
        |-> $stable(led_green) && $stable(led_red)) else $error("led moved");
endmodule : blrg_checker

// ==== blrg_far_model.sv ====
// Purpose: Rear connector model with pulled-up input pins.
// Assumes: Unattached pins float to the pull-up level.
// Notes:   The configuration signal is a plain level.
`timescale 1ns/1ns
module blrg_far_model
(
    input wire logic       gpio_mode,
    input wire logic [4:0] attach,
    input wire logic [4:0] level,
    output logic           rear_gpio_enable,
    output logic [4:0]     rear_input_bit
);
    assign rear_gpio_enable = gpio_mode;
    assign rear_input_bit = (attach & level) | ~attach;
endmodule : blrg_far_model

// ==== blrg_tb_top.sv ====
// Purpose: Directed bus tests of the LED and rear GPIO registers.
// Assumes: Reads wait one cycle, writes land on pins two edges later.
// Notes:   One POST code strobe is sent while the LEDs are in POST mode.
`timescale 1ns/1ns
module blrg_regs_tb_top;
    logic        clk, rstn, rd, wr, gm, wait_q, ge;
    logic [11:0] adr;
    logic [31:0] wd, rdata, got;
    logic [3:0]  be, lg, lr;
    logic [4:0]  att, lvl, gin;
    logic [1:0]  resp, rsp;
    logic [2:0]  gout;
    logic [7:0]  pc;
    logic        pcv;
    int          error_cnt, checks;
    blrg_regs blrg_regs_inst (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wait_q), .avs_response(resp), .post_code_in(pc),
        .post_code_valid(pcv), .rear_gpio_enable(ge), .rear_input_bit(gin),
        .rear_output_bit(gout), .led_green(lg), .led_red(lr));
    blrg_far_model blrg_far_model_inst (.gpio_mode(gm), .attach(att), .level(lvl),
        .rear_gpio_enable(ge), .rear_input_bit(gin));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic e);
        @(posedge clk);
        rd  <= !w;
        wr  <= w;
        adr <= a;
        wd  <= {24'h0, d};
        be  <= {3'h0, e};
        do @(posedge clk); while (wait_q !== 1'h0);
        got = rdata;
        rsp = resp;
        rd  <= 1'h0;
        wr  <= 1'h0;
    endtask : bus
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        bus(1'h1, a, d, 1'h1);
    endtask : wreg
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'h0, a, 8'h00, 1'h1);
        cmp(got, e);
    endtask : rchk
    task automatic end_of_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial
    begin
        #20000;
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        rstn = 0; rd = 0; wr = 0; adr = 0; wd = 0; be = 0; gm = 0; att = 0; lvl = 0;
        error_cnt = 0; checks = 0; pc = 0; pcv = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        rchk(12'hA44, 32'h0);
        rchk(12'hA48, 32'h0);
        gm <= 1'h1;
        repeat (4) @(posedge clk);
        rchk(12'hA4C, 32'h1F);
        att <= 5'h1E;
        lvl <= 5'h0A;
        repeat (3) @(posedge clk);
        rchk(12'hA4C, 32'h0B);
        wreg(12'hA4C, 8'h00);
        rchk(12'hA4C, 32'h0B);
        wreg(12'hA48, 8'hFD);
        repeat (2) @(posedge clk);
        cmp(gout, 3'h5);
        rchk(12'hA48, 32'h05);
        bus(1'h1, 12'hA48, 8'h02, 1'h0);
        rchk(12'hA48, 32'h05);
        gm <= 1'h0;
        repeat (4) @(posedge clk);
        cmp(gout, 3'h0);
        rchk(12'hA4C, 32'h1F);
        wreg(12'hA44, 8'h93);
        repeat (2) @(posedge clk);
        cmp({lr, lg}, 8'h00);
        pc  <= 8'hA6;
        pcv <= 1'h1;
        @(posedge clk);
        pcv <= 1'h0;
        repeat (2) @(posedge clk);
        cmp({lr, lg}, 8'h06);
        rchk(12'hA50, 32'hA6);
        wreg(12'hA40, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                wreg(12'hA44, {2'h2, i[1:0], 2'h0, c[1:0]});
                repeat (2) @(posedge clk);
                cmp({lr[i], lg[i]}, c[1:0]);
                wreg(12'hA44, {2'h0, i[1:0], 4'h0});
                rchk(12'hA44, {26'h0, i[1:0], 2'h0, c[1:0]});
            end
        end
        bus(1'h0, 12'hA60, 8'h00, 1'h1);
        cmp(rsp, 2'h2);
        wreg(12'hA40, 8'h05);
        repeat (2) @(posedge clk);
        cmp({lr, lg}, 8'h00);
        end_of_test();
    end
endmodule : blrg_regs_tb_top
bind blrg_regs blrg_checker blrg_checker_inst (.clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .post_code_valid(post_code_valid),
    .rear_gpio_enable(rear_gpio_enable), .rear_input_bit(rear_input_bit),
    .rear_output_bit(rear_output_bit), .led_green(led_green), .led_red(led_red));
